// [hdl/timer_flag_unit.sv]
// Event flag register of one 16-bit timer
`timescale 1ns/1ps
module timer_flag_unit (
   input  wire logic        i_clock,          // System clock
   input  wire logic        i_rstn,           // Reset, active low
   input  wire logic        i_tick,           // Timer clock enable
   input  wire logic [15:0] i_count,          // Counter value
   input  wire logic [15:0] i_compare_a,      // Compare A value
   input  wire logic [15:0] i_compare_b,      // Compare B value
   input  wire logic [15:0] i_capture_value,  // Capture value
   input  wire logic [3:0]  i_waveform,       // Waveform select
   input  wire logic        i_force_a,        // Forced compare A strobe
   input  wire logic        i_force_b,        // Forced compare B strobe
   input  wire logic        i_capture_event,  // Capture event
   input  wire logic [7:0]  i_clear_mask,     // Clear mask
   input  wire logic [3:0]  i_vector_ack,     // Vector taken pulses
   output logic      [7:0]  o_flags,          // Flag register
   output logic      [1:0]  o_force_action    // Forced actions
);
   import timer_flag_pkg::*;

   // ---------------------------------------------------------------
   // Match detection, flagged on the following tick
   // ---------------------------------------------------------------
   logic [3:0]      pending;
   logic [3:0]      next_pending;
   logic [7:0]      next_flags;
   logic [1:0]      next_force_action;
   logic [15:0]     top;
   overflow_point_t ovf_point;
   logic            ovf_hit;

   always_comb begin
      top       = mode_top(i_waveform, i_compare_a, i_capture_value);
      ovf_point = overflow_point(i_waveform);
      case (ovf_point)
         OVF_AT_MAX:    ovf_hit = (i_count == COUNT_MAX);
         OVF_AT_TOP:    ovf_hit = (i_count == top);
         OVF_AT_BOTTOM: ovf_hit = (i_count == COUNT_BOTTOM);
         default:       ovf_hit = 1'b0;
      endcase
      next_pending = pending;
      if (i_tick) begin
         next_pending[VEC_COMPARE_A] = (i_count == i_compare_a);
         next_pending[VEC_COMPARE_B] = (i_count == i_compare_b);
         next_pending[VEC_OVERFLOW]  = ovf_hit;
         next_pending[VEC_CAPTURE]   = capture_is_top(i_waveform) && (i_count == top);
      end
   end

   always_comb begin
      next_flags = o_flags;
      if (i_vector_ack[VEC_COMPARE_A]) next_flags[COMPARE_A_BIT] = 1'b0;
      if (i_vector_ack[VEC_COMPARE_B]) next_flags[COMPARE_B_BIT] = 1'b0;
      if (i_vector_ack[VEC_OVERFLOW])  next_flags[OVERFLOW_BIT]  = 1'b0;
      if (i_vector_ack[VEC_CAPTURE])   next_flags[CAPTURE_BIT]   = 1'b0;
      next_flags = next_flags & ~i_clear_mask;
      // Sets applied last, so they win
      if (i_tick) begin
         if (pending[VEC_COMPARE_A]) next_flags[COMPARE_A_BIT] = 1'b1;
         if (pending[VEC_COMPARE_B]) next_flags[COMPARE_B_BIT] = 1'b1;
         if (pending[VEC_OVERFLOW])  next_flags[OVERFLOW_BIT]  = 1'b1;
         if (pending[VEC_CAPTURE])   next_flags[CAPTURE_BIT]   = 1'b1;
      end
      // Pin capture, unless capture value is top
      if (i_capture_event && !capture_is_top(i_waveform)) next_flags[CAPTURE_BIT] = 1'b1;
      next_flags = next_flags & FLAGS_USED;
      // Forced strobes reach the output action only
      next_force_action = {i_force_b, i_force_a};
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pending        <= 4'h0;
         o_flags        <= FLAGS_RESET;
         o_force_action <= 2'h0;
      end else begin
         pending        <= next_pending;
         o_flags        <= next_flags;
         o_force_action <= next_force_action;
      end
   end

endmodule : timer_flag_unit

// [hdl/timer_interrupt_flag_logic.sv]
// Event flag registers and interrupt requests of timers 1, 3 and 4
`timescale 1ns/1ps
module timer_interrupt_flag_logic (
   input  wire logic        i_clock,              // System clock, 250 MHz
   input  wire logic        i_rstn,               // Reset, active low
   // Data-space access
   input  wire logic [7:0]  i_data_addr,          // Data-space address
   input  wire logic        i_data_write,         // Data-space write strobe
   input  wire logic        i_data_read,          // Data-space read strobe
   // I/O access
   input  wire logic [5:0]  i_io_addr,            // I/O address
   input  wire logic        i_io_write,           // I/O write strobe
   input  wire logic        i_io_read,            // I/O read strobe
   input  wire logic [7:0]  i_write_data,         // Write data
   output logic      [7:0]  o_read_data,          // Read data
   output logic             o_read_hit,           // Read hit
   // Timer 1
   input  wire logic        i_timer1_tick,        // Clock enable
   input  wire logic [15:0] i_timer1_count,       // Counter
   input  wire logic [15:0] i_timer1_compare_a_value, // Compare A
   input  wire logic [15:0] i_timer1_compare_b_value, // Compare B
   input  wire logic [15:0] i_timer1_capture_value,   // Capture register
   input  wire logic [3:0]  i_timer1_waveform_select, // Waveform mode
   input  wire logic        i_timer1_force_compare_a, // Forced A strobe
   input  wire logic        i_timer1_force_compare_b, // Forced B strobe
   input  wire logic        i_timer1_capture_event,   // Capture pin event
   input  wire logic [3:0]  i_timer1_irq_enable,  // Enables (cap,B,A,ovf)
   input  wire logic [3:0]  i_timer1_vector_ack,  // Vector taken
   output logic      [3:0]  o_timer1_irq,         // Requests
   output logic      [1:0]  o_timer1_force_action, // Forced action (B,A)
   // Timer 3
   input  wire logic        i_timer3_tick,        // Clock enable
   input  wire logic [15:0] i_timer3_count,       // Counter
   input  wire logic [15:0] i_timer3_compare_a_value, // Compare A
   input  wire logic [15:0] i_timer3_compare_b_value, // Compare B
   input  wire logic [15:0] i_timer3_capture_value,   // Capture register
   input  wire logic [3:0]  i_timer3_waveform_select, // Waveform mode
   input  wire logic        i_timer3_force_compare_a, // Forced A strobe
   input  wire logic        i_timer3_force_compare_b, // Forced B strobe
   input  wire logic        i_timer3_capture_event,   // Capture pin event
   input  wire logic [3:0]  i_timer3_irq_enable,  // Enables (cap,B,A,ovf)
   input  wire logic [3:0]  i_timer3_vector_ack,  // Vector taken
   output logic      [3:0]  o_timer3_irq,         // Requests
   output logic      [1:0]  o_timer3_force_action, // Forced action (B,A)
   // Timer 4
   input  wire logic        i_timer4_tick,        // Clock enable
   input  wire logic [15:0] i_timer4_count,       // Counter
   input  wire logic [15:0] i_timer4_compare_a_value, // Compare A
   input  wire logic [15:0] i_timer4_compare_b_value, // Compare B
   input  wire logic [15:0] i_timer4_capture_value,   // Capture register
   input  wire logic [3:0]  i_timer4_waveform_select, // Waveform mode
   input  wire logic        i_timer4_force_compare_a, // Forced A strobe
   input  wire logic        i_timer4_force_compare_b, // Forced B strobe
   input  wire logic        i_timer4_capture_event,   // Capture pin event
   input  wire logic [3:0]  i_timer4_irq_enable,  // Enables (cap,B,A,ovf)
   input  wire logic [3:0]  i_timer4_vector_ack,  // Vector taken
   output logic      [3:0]  o_timer4_irq,         // Requests
   output logic      [1:0]  o_timer4_force_action, // Forced action (B,A)
   // Flag views and global enable
   input  wire logic        i_global_irq_enable,  // Global enable
   output logic      [7:0]  o_timer1_event_flags, // Timer 1 flag register
   output logic      [7:0]  o_timer3_event_flags, // Timer 3 flag register
   output logic      [7:0]  o_timer4_event_flags  // Timer 4 flag register
);
   import timer_flag_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // One-hot timer select for an address
   function automatic logic [2:0] flag_select(input logic [7:0] addr);
      flag_select = {addr == TIMER4_FLAGS_ADDR, addr == TIMER3_FLAGS_ADDR,
                     addr == TIMER1_FLAGS_ADDR};
   endfunction : flag_select

   logic [7:0] io_as_data;
   logic [2:0] write_sel;
   logic [2:0] read_sel;
   logic       read_strobe;

   always_comb begin
      // I/O address maps 0x20 higher in data space
      io_as_data  = {2'b00, i_io_addr} + IO_ADDR_OFFSET;
      write_sel   = 3'h0;
      read_sel    = 3'h0;
      read_strobe = i_data_read | i_io_read;
      if (i_data_write) write_sel = flag_select(i_data_addr);
      else if (i_io_write && io_as_data <= IO_ADDR_LAST) write_sel = flag_select(io_as_data);
      if (i_data_read) read_sel = flag_select(i_data_addr);
      else if (i_io_read && io_as_data <= IO_ADDR_LAST) read_sel = flag_select(io_as_data);
   end

   // ---------------------------------------------------------------
   // Flag units
   // ---------------------------------------------------------------
   logic [TIMER_COUNT-1:0]       tick;
   logic [TIMER_COUNT-1:0][15:0] count;
   logic [TIMER_COUNT-1:0][15:0] cmp_a;
   logic [TIMER_COUNT-1:0][15:0] cmp_b;
   logic [TIMER_COUNT-1:0][15:0] cap_val;
   logic [TIMER_COUNT-1:0][3:0]  wave;
   logic [TIMER_COUNT-1:0]       force_a;
   logic [TIMER_COUNT-1:0]       force_b;
   logic [TIMER_COUNT-1:0]       cap_evt;
   logic [TIMER_COUNT-1:0][3:0]  ack;
   logic [TIMER_COUNT-1:0][3:0]  enable;
   logic [TIMER_COUNT-1:0][7:0]  flags;
   logic [TIMER_COUNT-1:0][1:0]  force_act;
   logic [TIMER_COUNT-1:0][3:0]  irq;

   assign tick    = {i_timer4_tick, i_timer3_tick, i_timer1_tick};
   assign count   = {i_timer4_count, i_timer3_count, i_timer1_count};
   assign cmp_a   = {i_timer4_compare_a_value, i_timer3_compare_a_value,
                     i_timer1_compare_a_value};
   assign cmp_b   = {i_timer4_compare_b_value, i_timer3_compare_b_value,
                     i_timer1_compare_b_value};
   assign cap_val = {i_timer4_capture_value, i_timer3_capture_value, i_timer1_capture_value};
   assign wave    = {i_timer4_waveform_select, i_timer3_waveform_select,
                     i_timer1_waveform_select};
   assign force_a = {i_timer4_force_compare_a, i_timer3_force_compare_a,
                     i_timer1_force_compare_a};
   assign force_b = {i_timer4_force_compare_b, i_timer3_force_compare_b,
                     i_timer1_force_compare_b};
   assign cap_evt = {i_timer4_capture_event, i_timer3_capture_event, i_timer1_capture_event};
   assign ack     = {i_timer4_vector_ack, i_timer3_vector_ack, i_timer1_vector_ack};
   assign enable  = {i_timer4_irq_enable, i_timer3_irq_enable, i_timer1_irq_enable};

   for (genvar t = 0; t < TIMER_COUNT; t++) begin : g_timer
      timer_flag_unit u_flags (
         .i_clock         (i_clock),
         .i_rstn          (rst_sync),
         .i_tick          (tick[t]),
         .i_count         (count[t]),
         .i_compare_a     (cmp_a[t]),
         .i_compare_b     (cmp_b[t]),
         .i_capture_value (cap_val[t]),
         .i_waveform      (wave[t]),
         .i_force_a       (force_a[t]),
         .i_force_b       (force_b[t]),
         .i_capture_event (cap_evt[t]),
         // Write data is the clear mask
         .i_clear_mask    (write_sel[t] ? i_write_data : 8'h00),
         .i_vector_ack    (ack[t]),
         .o_flags         (flags[t]),
         .o_force_action  (force_act[t])
      );

      // Request needs flag, enable and global enable
      assign irq[t] = {flags[t][CAPTURE_BIT], flags[t][COMPARE_B_BIT],
                       flags[t][COMPARE_A_BIT], flags[t][OVERFLOW_BIT]} &
                      enable[t] & {4{i_global_irq_enable}};
   end

   assign o_timer1_irq          = irq[0];
   assign o_timer3_irq          = irq[1];
   assign o_timer4_irq          = irq[2];
   assign o_timer1_force_action = force_act[0];
   assign o_timer3_force_action = force_act[1];
   assign o_timer4_force_action = force_act[2];
   assign o_timer1_event_flags  = flags[0];
   assign o_timer3_event_flags  = flags[1];
   assign o_timer4_event_flags  = flags[2];

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [7:0] next_read_data;
   logic       next_read_hit;

   always_comb begin
      next_read_data = o_read_data;
      next_read_hit  = o_read_hit;
      if (read_strobe) begin
         next_read_data = 8'h00;
         next_read_hit  = |read_sel;
         for (int t = 0; t < TIMER_COUNT; t++) begin
            if (read_sel[t]) next_read_data = flags[t];
         end
      end
   end

   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync) begin
         o_read_data <= 8'h00;
         o_read_hit  <= 1'b0;
      end else begin
         o_read_data <= next_read_data;
         o_read_hit  <= next_read_hit;
      end
   end

endmodule : timer_interrupt_flag_logic

// [shared/timer_flag_pkg.sv]
// Constants, mode decoding and flag layout for the timer event flag logic
// Notes on behaviour
// - Compare flags set one tick after count equals compare value.
// - Forced compare strobes never set compare flags.
// - Taking a compare vector clears its compare flag.
// - Writing one to a flag bit clears that flag.
// - Overflow sets at MAX in normal and clear-on-match modes, else per mode.
// - Taking the overflow vector clears the overflow flag.
// - A capture pin event sets the capture flag unless capture value is top.
// - With capture value as top, reaching top sets the capture flag.
// - Taking the capture vector clears the capture flag.
// - Capture bit 5, B bit 2, A bit 1, overflow bit 0; reset zero.
// - Flags at data-space offsets and at I/O addresses 0x20 lower.
// - Request only while flag, its enable and global enable are set.
package timer_flag_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [7:0] TIMER1_FLAGS_ADDR = 8'h36;
   localparam logic [7:0] TIMER3_FLAGS_ADDR = 8'h38;
   localparam logic [7:0] TIMER4_FLAGS_ADDR = 8'h39;
   localparam logic [7:0] IO_ADDR_OFFSET    = 8'h20;
   localparam logic [7:0] IO_ADDR_LAST      = 8'h3f;

   // ---------------------------------------------------------------
   // Flag register layout
   // ---------------------------------------------------------------
   localparam int          CAPTURE_BIT   = 5;
   localparam int          COMPARE_B_BIT = 2;
   localparam int          COMPARE_A_BIT = 1;
   localparam int          OVERFLOW_BIT  = 0;
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;
   localparam logic [7:0]  FLAGS_USED    = 8'h27;
   localparam int          TIMER_COUNT   = 3;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   localparam logic [15:0] COUNT_BOTTOM  = 16'h0000;

   // Vector bit order
   localparam int VEC_OVERFLOW  = 0;
   localparam int VEC_COMPARE_A = 1;
   localparam int VEC_COMPARE_B = 2;
   localparam int VEC_CAPTURE   = 3;

   // ---------------------------------------------------------------
   // Waveform modes
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_NORMAL      = 4'h0;
   localparam logic [3:0] MODE_CLEAR_CMP   = 4'h4;
   localparam logic [3:0] MODE_CLEAR_CAP   = 4'hc;

   typedef enum logic [1:0] {
      OVF_AT_MAX,
      OVF_AT_TOP,
      OVF_AT_BOTTOM,
      OVF_NEVER
   } overflow_point_t;

   // Top of the count
   function automatic logic [15:0] mode_top(input logic [3:0]  mode,
                                            input logic [15:0] compare_a,
                                            input logic [15:0] capture_value);
      case (mode)
         4'h1, 4'h5: mode_top = 16'h00ff;
         4'h2, 4'h6: mode_top = 16'h01ff;
         4'h3, 4'h7: mode_top = 16'h03ff;
         4'h4, 4'h9, 4'hb, 4'hf: mode_top = compare_a;
         4'h8, 4'ha, 4'hc, 4'he: mode_top = capture_value;
         default: mode_top = COUNT_MAX;
      endcase
   endfunction : mode_top

   // Capture value is top
   function automatic logic capture_is_top(input logic [3:0] mode);
      capture_is_top = mode[3] && !mode[0];
   endfunction : capture_is_top

   // Where overflow is flagged
   function automatic overflow_point_t overflow_point(input logic [3:0] mode);
      case (mode)
         MODE_NORMAL, MODE_CLEAR_CMP, MODE_CLEAR_CAP: overflow_point = OVF_AT_MAX;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: overflow_point = OVF_AT_TOP;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: overflow_point = OVF_AT_BOTTOM;
         default: overflow_point = OVF_NEVER;
      endcase
   endfunction : overflow_point

endpackage : timer_flag_pkg

// [verif/cpu_vector_model.sv]
// Processor model: takes one vector at a time
`timescale 1ns/1ps
module cpu_vector_model (
   input  wire logic       i_clock, // System clock
   input  wire logic       i_rstn,  // Reset, active low
   input  wire logic       i_slow,  // Late vector dispatch
   input  wire logic [3:0] i_irq,   // Pending requests
   output logic      [3:0] o_ack    // Vector taken pulses
);
   logic [1:0] wait_count;
   logic [1:0] next_wait_count;
   logic [3:0] next_ack;
   always_comb begin
      next_ack = 4'h0;
      next_wait_count = (i_irq != 4'h0) ? wait_count + 2'h1 : 2'h0;
      // vector only for a raised request
      if ((i_irq != 4'h0) && (o_ack == 4'h0) && (!i_slow || (wait_count == 2'h3))) begin
         next_ack = i_irq & (~i_irq + 4'h1);
         next_wait_count = 2'h0;
      end
   end
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         {wait_count, o_ack} <= 6'h00;
      end else begin
         {wait_count, o_ack} <= {next_wait_count, next_ack};
      end
   end
endmodule : cpu_vector_model

// [verif/timer_interrupt_flag_logic_sva.sv]
// Checks on timer 3 flags and the register port
`timescale 1ns/1ps
module timer_interrupt_flag_logic_sva
   import timer_flag_pkg::*;
(
   input wire logic        i_clock,                  // Clock
   input wire logic        i_rstn,                   // Reset, active low
   input wire logic [7:0]  i_data_addr,              // Address
   input wire logic        i_data_write,             // Write strobe
   input wire logic        i_data_read,              // Read strobe
   input wire logic [7:0]  i_write_data,             // Write data
   input wire logic [7:0]  o_read_data,              // Read data
   input wire logic        o_read_hit,               // Read hit
   input wire logic        i_timer3_tick,            // Tick
   input wire logic [15:0] i_timer3_count,           // Count
   input wire logic [15:0] i_timer3_compare_a_value, // Compare A
   input wire logic [3:0]  i_timer3_waveform_select, // Mode
   input wire logic        i_timer3_capture_event,   // Capture event
   input wire logic [3:0]  i_timer3_irq_enable,      // Enables
   input wire logic [3:0]  i_timer3_vector_ack,      // Vector taken
   input wire logic        i_global_irq_enable,      // Global enable
   input wire logic [3:0]  o_timer3_irq,             // Requests
   input wire logic [7:0]  o_timer3_event_flags      // Flags
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   logic       match_a;
   logic [7:0] flags;
   assign match_a = i_timer3_tick && (i_timer3_count == i_timer3_compare_a_value);
   assign flags = o_timer3_event_flags;
   a_irq_gate_check: assert property (
      o_timer3_irq == ({flags[5], flags[2:0]} & i_timer3_irq_enable & {4{i_global_irq_enable}}))
      else $error("irq mismatch");
   a_compare_a_set: assert property (
      match_a ##1 i_timer3_tick |=> flags[1])
      else $error("compare A not set");
   a_vector_clears_a: assert property (
      i_timer3_vector_ack[1] && !$past(match_a) |=> !flags[1])
      else $error("compare A not cleared");
   a_overflow_set: assert property (
      (i_timer3_tick && i_timer3_waveform_select == MODE_NORMAL && i_timer3_count == COUNT_MAX)
      ##1 i_timer3_tick |=> flags[0])
      else $error("overflow not set");
   a_capture_pin_set: assert property (
      i_timer3_capture_event && i_timer3_waveform_select == MODE_NORMAL |=> flags[5])
      else $error("capture not set");
   a_write_one_clear: assert property (
      i_data_write && i_data_addr == TIMER3_FLAGS_ADDR && i_write_data[5] &&
      !i_timer3_capture_event && i_timer3_waveform_select == MODE_NORMAL &&
      $past(i_timer3_waveform_select) == MODE_NORMAL |=> !flags[5])
      else $error("capture not cleared");
   a_read_returns_flags: assert property (
      i_data_read && i_data_addr == TIMER3_FLAGS_ADDR |=> o_read_hit && o_read_data == $past(flags))
      else $error("read data wrong");
   a_read_unmapped: assert property (
      i_data_read && i_data_addr == 8'h37 |=> !o_read_hit && o_read_data == 8'h00)
      else $error("unmapped read answered");
   a_unused_bits_zero: assert property (
      (flags & ~FLAGS_USED) == 8'h00)
      else $error("unused flag bit set");
endmodule : timer_interrupt_flag_logic_sva
bind timer_interrupt_flag_logic timer_interrupt_flag_logic_sva timer_interrupt_flag_logic_sva_i (.*);

// [verif/timer_interrupt_flag_logic_tb_top.sv]
// Bench for the timer flag logic
`timescale 1ns/1ps
module timer_interrupt_flag_logic_tb_top;
   import timer_flag_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rstn = 1'b0;
   logic        dwr = 1'b0, drd = 1'b0, iowr = 1'b0, iord = 1'b0, hit;
   logic        fa = 1'b0, fb = 1'b0, cap = 1'b0, gie = 1'b0, slow = 1'b0, tick1 = 1'b1;
   logic [5:0]  ioa = 6'h00;
   logic [7:0]  da = 8'h00, wd = 8'h00, rdata, f1, f3, f4;
   logic [15:0] cnt = 16'h1234, cmpa = 16'h0100, cmpb = 16'h0200, capv = 16'h0300;
   logic [3:0]  mode = 4'h0, en = 4'h0, ack1 = 4'h0, ack4 = 4'h0, ack3, irq1, irq3, irq4;
   logic [7:0]  maps [3] = '{TIMER1_FLAGS_ADDR, TIMER3_FLAGS_ADDR, TIMER4_FLAGS_ADDR};
   logic [31:0] r;
   integer      bad_count = 0, checks_done = 0, seed = 91, i, m;
   always #2 i_clock = ~i_clock;
   timer_interrupt_flag_logic timer_interrupt_flag_logic_i (
      .i_clock, .i_rstn, .i_data_addr(da), .i_data_write(dwr), .i_data_read(drd),
      .i_io_addr(ioa), .i_io_write(iowr), .i_io_read(iord), .i_write_data(wd),
      .o_read_data(rdata), .o_read_hit(hit), .i_global_irq_enable(gie),
      .i_timer1_tick(tick1), .i_timer1_count(cnt), .i_timer1_compare_a_value(cmpa),
      .i_timer1_compare_b_value(cmpb), .i_timer1_capture_value(capv),
      .i_timer1_waveform_select(mode), .i_timer1_force_compare_a(fa),
      .i_timer1_force_compare_b(fb), .i_timer1_capture_event(cap), .i_timer1_irq_enable(en),
      .i_timer1_vector_ack(ack1), .o_timer1_irq(irq1), .o_timer1_force_action(),
      .i_timer3_tick(1'b1), .i_timer3_count(cnt), .i_timer3_compare_a_value(cmpa),
      .i_timer3_compare_b_value(cmpb), .i_timer3_capture_value(capv),
      .i_timer3_waveform_select(mode), .i_timer3_force_compare_a(fa),
      .i_timer3_force_compare_b(fb), .i_timer3_capture_event(cap), .i_timer3_irq_enable(en),
      .i_timer3_vector_ack(ack3), .o_timer3_irq(irq3), .o_timer3_force_action(),
      .i_timer4_tick(1'b1), .i_timer4_count(cnt), .i_timer4_compare_a_value(cmpa),
      .i_timer4_compare_b_value(cmpb), .i_timer4_capture_value(capv),
      .i_timer4_waveform_select(mode), .i_timer4_force_compare_a(fa),
      .i_timer4_force_compare_b(fb), .i_timer4_capture_event(cap), .i_timer4_irq_enable(en),
      .i_timer4_vector_ack(ack4), .o_timer4_irq(irq4), .o_timer4_force_action(),
      .o_timer1_event_flags(f1), .o_timer3_event_flags(f3), .o_timer4_event_flags(f4));
   cpu_vector_model cpu_vector_model_i (.i_clock, .i_rstn, .i_slow(slow), .i_irq(irq3),
      .o_ack(ack3));
   function automatic logic [8:0] after_set(input logic [7:0] old, input logic [7:0] set_m,
                                            input logic [7:0] clr_m);
      after_set = {1'b0, ((old & ~clr_m) | set_m) & FLAGS_USED};
   endfunction : after_set
   task chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task cyc(input integer n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : cyc
   task rd(input logic io, input logic [7:0] a, input logic [8:0] exp);
      @(posedge i_clock);
      {drd, iord, da, ioa} <= {!io, io, a, 6'(a - IO_ADDR_OFFSET)};
      @(posedge i_clock);
      {drd, iord} <= 2'b00;
      #1 chk({hit, rdata}, exp);
   endtask : rd
   task wr(input logic io, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      {dwr, iowr, da, ioa, wd} <= {!io, io, a, 6'(a - IO_ADDR_OFFSET), d};
      @(posedge i_clock);
      {dwr, iowr} <= 2'b00;
   endtask : wr
   task hit_count(input logic [15:0] v, input logic ev, input logic f);
      @(posedge i_clock);
      {cnt, cap, fb} <= {v, ev, f};
      @(posedge i_clock);
      {cnt, cap, fb} <= {16'h1234, 2'b00};
   endtask : hit_count
   task complete_run;
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20000) @(posedge i_clock);
      bad_count++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge i_clock);
      i_rstn <= 1'b1;
      cyc(3);
      for (m = 0; m < 3; m = m + 1) rd(m[0], maps[m], {1'b1, FLAGS_RESET});
      rd(1'b1, 8'h37, 9'h000);
      hit_count(cmpa, 1'b0, 1'b1);
      cyc(1);
      chk({1'b0, f3}, after_set(FLAGS_RESET, 8'h02, 8'h00));
      chk({1'b0, f4}, after_set(FLAGS_RESET, 8'h02, 8'h00));
      wr(1'b1, TIMER3_FLAGS_ADDR, 8'hfd);
      rd(1'b1, TIMER3_FLAGS_ADDR, {1'b1, 8'h02});
      wr(1'b0, TIMER3_FLAGS_ADDR, 8'h02);
      rd(1'b0, TIMER3_FLAGS_ADDR, {1'b1, 8'h00});
      for (m = 0; m < 3; m = m + 1) begin
         @(posedge i_clock);
         {mode, slow} <= {(m == 0) ? MODE_NORMAL : (m == 1) ? MODE_CLEAR_CMP :
                          MODE_CLEAR_CAP, m[0]};
         hit_count(COUNT_MAX, 1'b0, 1'b0);
         cyc(1);
         chk({1'b0, f3}, after_set(FLAGS_RESET, 8'h01, 8'h00));
         @(posedge i_clock);
         {en, gie} <= 5'h03;
         cyc(8);
         chk({1'b0, f3}, 9'h000);
         @(posedge i_clock);
         {en, gie, mode} <= {5'h00, MODE_NORMAL};
      end
      hit_count(16'h1234, 1'b1, 1'b0);
      cyc(0);
      chk({1'b0, f3}, after_set(FLAGS_RESET, 8'h20, 8'h00));
      wr(1'b0, TIMER3_FLAGS_ADDR, 8'h20);
      @(posedge i_clock);
      mode <= MODE_CLEAR_CAP;
      hit_count(16'h1234, 1'b1, 1'b0);
      cyc(1);
      chk({1'b0, f3}, 9'h000);
      hit_count(capv, 1'b0, 1'b0);
      cyc(1);
      chk({1'b0, f3}, after_set(FLAGS_RESET, 8'h20, 8'h00));
      @(posedge i_clock);
      {en, gie} <= 5'h11;
      cyc(8);
      chk({1'b0, f3}, 9'h000);
      @(posedge i_clock);
      {mode, en, gie, cnt} <= {MODE_NORMAL, 5'h00, cmpa};
      @(posedge i_clock);
      {cnt, dwr, da, wd} <= {16'h1234, 1'b1, TIMER3_FLAGS_ADDR, 8'h02};
      @(posedge i_clock);
      dwr <= 1'b0;
      #1 chk({1'b0, f3}, after_set(FLAGS_RESET, 8'h02, 8'h02));
      for (i = 0; i < 400; i = i + 1) begin
         @(posedge i_clock);
         r = $random(seed);
         case (r[1:0])
            2'd0: cnt <= cmpa;
            2'd1: cnt <= capv;
            2'd2: cnt <= COUNT_MAX;
            default: cnt <= r[16] ? cmpb : r[31:16];
         endcase
         {mode, fa, fb, cap, dwr, drd, iowr, iord} <= r[12:2];
         {da, ioa, wd} <= {8'h36 + {6'h00, r[15:14]}, 6'h16 + {4'h0, r[17:16]}, r[25:18]};
         {en, gie, slow, tick1, ack1, ack4} <= {r[29:26], r[30], r[31], r[0], r[5:2], r[9:6]};
      end
      @(posedge i_clock);
      {fa, fb, cap, dwr, drd, iowr, iord, gie, tick1} <= 9'h001;
      {cnt, mode, en, ack1, ack4} <= {16'h1234, 16'h0000};
      cyc(3);
      for (m = 0; m < 3; m = m + 1) begin
         wr(m[0], maps[m], 8'hff);
         rd(!m[0], maps[m], {1'b1, FLAGS_RESET});
      end
      complete_run;
   end
endmodule : timer_interrupt_flag_logic_tb_top
